// ### nml_unit.sv
// axi4-lite register front end of the negative low-halfword multiply-accumulate unit
// assumes one clock, synchronous active-low reset, and an axi4-lite master
//
// Notes on behaviour
// RULE_01: the multiplier operands are the low halfwords of both source registers.
// RULE_02: the signed 32-bit halfword product is subtracted from the destination word.
// RULE_03: modulo variants write back the low 32 bits of the 33-bit difference unchanged.
// RULE_04: saturating variants write the nearest 32-bit limit when the difference overflows.
// RULE_05: without record or overflow enable, exception bits and condition field stay put.
// RULE_06: record alone updates only the condition field from the written result.
// RULE_07: overflow enable alone updates the overflow and summary bits only.
// RULE_08: overflow enable with record updates the overflow bits and the condition field.
// RULE_09: overflow follows the 33-bit range check, summary is sticky, condition holds lt/gt/eq/summary.
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
module nml_unit (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ****************************************
    // decode helpers
    // ****************************************
    function automatic logic [2:0] reg_sel(input logic [7:0] addr);
        logic [2:0] sel;
        sel = nml_pkg::SEL_NONE;
        case ({addr[7:2], 2'h0})
            nml_pkg::OFS_FIRST_SRC: sel = nml_pkg::SEL_FIRST_SRC;
            nml_pkg::OFS_SECOND_SRC: sel = nml_pkg::SEL_SECOND_SRC;
            nml_pkg::OFS_DEST: sel = nml_pkg::SEL_DEST;
            nml_pkg::OFS_CONTROL: sel = nml_pkg::SEL_CONTROL;
            nml_pkg::OFS_EXCEPTION: sel = nml_pkg::SEL_EXCEPTION;
            nml_pkg::OFS_CONDITION: sel = nml_pkg::SEL_CONDITION;
            default: sel = nml_pkg::SEL_NONE;
        endcase
        return sel;
    endfunction : reg_sel

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // ****************************************
    // state and arithmetic
    // ****************************************
    nml_pkg::nml_state_s state_reg;
    nml_pkg::nml_state_s state_next;
    logic [31:0] core_result;
    logic core_excess;
    logic [2:0] wsel;
    logic [31:0] wword;
    logic [31:0] rword;
    logic execute;
    logic new_summary;

    nml_core u_core (
        .first_source_register(state_reg.regs.first_source_register),
        .second_source_register(state_reg.regs.second_source_register),
        .acc(state_reg.regs.dest),
        .saturate(wword[nml_pkg::CTL_SATURATE_BIT]),
        .result(core_result),
        .excess(core_excess)
    );

    assign s_axi_awready = !state_reg.aw_have && !state_reg.bvalid;
    assign s_axi_wready = !state_reg.w_have && !state_reg.bvalid;
    assign s_axi_arready = !state_reg.rvalid;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        state_next = state_reg;
        wsel = reg_sel(state_reg.aw_addr);
        wword = merge(WORD_READBACK(state_reg.regs, wsel), state_reg.w_data, state_reg.w_strb);
        execute = 1'b0;
        new_summary = state_reg.regs.summary_flag;
        rword = WORD_READBACK(state_reg.regs, reg_sel(s_axi_araddr));

        // write address and data are caught independently
        if (s_axi_awvalid && s_axi_awready) begin
            state_next.aw_have = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            state_next.w_have = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
        end

        // commit once both halves are held
        if (state_reg.aw_have && state_reg.w_have && !state_reg.bvalid) begin
            state_next.aw_have = 1'b0;
            state_next.w_have = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = nml_pkg::RESP_OKAY;
            case (wsel)
                nml_pkg::SEL_FIRST_SRC: state_next.regs.first_source_register = wword;
                nml_pkg::SEL_SECOND_SRC: state_next.regs.second_source_register = wword;
                nml_pkg::SEL_DEST: state_next.regs.dest = wword;
                nml_pkg::SEL_CONTROL: begin
                    state_next.regs.mode.saturate = wword[nml_pkg::CTL_SATURATE_BIT];
                    state_next.regs.mode.ovf_enable = wword[nml_pkg::CTL_OVF_ENABLE_BIT];
                    state_next.regs.mode.record = wword[nml_pkg::CTL_RECORD_BIT];
                    execute = state_reg.w_strb[0] && wword[nml_pkg::CTL_EXECUTE_BIT];
                end
                nml_pkg::SEL_EXCEPTION: begin
                    state_next.regs.arith_excess_flag = wword[nml_pkg::EXC_EXCESS_BIT];
                    state_next.regs.summary_flag = wword[nml_pkg::EXC_SUMMARY_BIT];
                end
                nml_pkg::SEL_CONDITION: state_next.regs.first_condition_field = wword[3:0];
                default: state_next.bresp = nml_pkg::RESP_SLVERR;
            endcase
        end

        // one instruction per execute write; flags follow the variant bits
        if (execute) begin
            state_next.regs.dest = core_result; // RULE_03 RULE_04
            if (wword[nml_pkg::CTL_OVF_ENABLE_BIT]) begin // RULE_05
                state_next.regs.arith_excess_flag = core_excess; // RULE_07 RULE_08 RULE_09
                new_summary = state_reg.regs.summary_flag | core_excess; // RULE_09
                state_next.regs.summary_flag = new_summary; // RULE_07 RULE_08
            end
            if (wword[nml_pkg::CTL_RECORD_BIT]) begin // RULE_05
                state_next.regs.first_condition_field[nml_pkg::CND_LESS_BIT] = core_result[31]; // RULE_06 RULE_08 RULE_09
                state_next.regs.first_condition_field[nml_pkg::CND_GREATER_BIT] =
                    !core_result[31] && (core_result != nml_pkg::WORD_ZERO); // RULE_09
                state_next.regs.first_condition_field[nml_pkg::CND_EQUAL_BIT] =
                    core_result == nml_pkg::WORD_ZERO; // RULE_09
                state_next.regs.first_condition_field[nml_pkg::CND_SUMMARY_BIT] = new_summary; // RULE_09
            end
            // neither option set: exception bits and condition field are left as they were
        end

        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end

        // read channel
        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            state_next.rvalid = 1'b1;
            state_next.rdata = rword;
            state_next.rresp = (reg_sel(s_axi_araddr) == nml_pkg::SEL_NONE) ?
                nml_pkg::RESP_SLVERR : nml_pkg::RESP_OKAY;
        end
    end

    // readback of one register; unmapped reads as zero
    function automatic logic [31:0] WORD_READBACK(input nml_pkg::nml_regs_s r,
                                                  input logic [2:0] sel);
        logic [31:0] w;
        w = nml_pkg::WORD_ZERO;
        case (sel)
            nml_pkg::SEL_FIRST_SRC: w = r.first_source_register;
            nml_pkg::SEL_SECOND_SRC: w = r.second_source_register;
            nml_pkg::SEL_DEST: w = r.dest;
            nml_pkg::SEL_CONTROL: begin
                w[nml_pkg::CTL_SATURATE_BIT] = r.mode.saturate;
                w[nml_pkg::CTL_OVF_ENABLE_BIT] = r.mode.ovf_enable;
                w[nml_pkg::CTL_RECORD_BIT] = r.mode.record;
            end
            nml_pkg::SEL_EXCEPTION: begin
                w[nml_pkg::EXC_EXCESS_BIT] = r.arith_excess_flag;
                w[nml_pkg::EXC_SUMMARY_BIT] = r.summary_flag;
            end
            nml_pkg::SEL_CONDITION: w[3:0] = r.first_condition_field;
            default: w = nml_pkg::WORD_ZERO;
        endcase
        return w;
    endfunction : WORD_READBACK

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg.aw_have <= 1'b0;
            state_reg.aw_addr <= nml_pkg::RST_ADDR;
            state_reg.w_have <= 1'b0;
            state_reg.w_data <= nml_pkg::RST_WORD;
            state_reg.w_strb <= nml_pkg::RST_STRB;
            state_reg.bvalid <= 1'b0;
            state_reg.bresp <= nml_pkg::RESP_OKAY;
            state_reg.rvalid <= 1'b0;
            state_reg.rdata <= nml_pkg::RST_WORD;
            state_reg.rresp <= nml_pkg::RESP_OKAY;
            state_reg.regs.first_source_register <= nml_pkg::RST_WORD;
            state_reg.regs.second_source_register <= nml_pkg::RST_WORD;
            state_reg.regs.dest <= nml_pkg::RST_WORD;
            state_reg.regs.mode <= nml_pkg::RST_MODE;
            state_reg.regs.arith_excess_flag <= 1'b0;
            state_reg.regs.summary_flag <= 1'b0;
            state_reg.regs.first_condition_field <= nml_pkg::RST_COND;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule : nml_unit

// ### nml_pkg.sv
// constants, register map and state layout of the negative low-halfword
// multiply-accumulate unit
// assumes a 32-bit axi4-lite register bus with 8-bit byte addresses
package nml_pkg;

    // ****************************************
    // bus widths and responses
    // ****************************************
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned STRB_W = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_FIRST_SRC = 8'h00;
    localparam logic [7:0] OFS_SECOND_SRC = 8'h04;
    localparam logic [7:0] OFS_DEST = 8'h08;
    localparam logic [7:0] OFS_CONTROL = 8'h0c;
    localparam logic [7:0] OFS_EXCEPTION = 8'h10;
    localparam logic [7:0] OFS_CONDITION = 8'h14;

    // register select codes
    localparam logic [2:0] SEL_FIRST_SRC = 3'h0;
    localparam logic [2:0] SEL_SECOND_SRC = 3'h1;
    localparam logic [2:0] SEL_DEST = 3'h2;
    localparam logic [2:0] SEL_CONTROL = 3'h3;
    localparam logic [2:0] SEL_EXCEPTION = 3'h4;
    localparam logic [2:0] SEL_CONDITION = 3'h5;
    localparam logic [2:0] SEL_NONE = 3'h7;

    // ****************************************
    // field positions
    // ****************************************
    localparam int unsigned CTL_EXECUTE_BIT = 0;
    localparam int unsigned CTL_SATURATE_BIT = 1;
    localparam int unsigned CTL_OVF_ENABLE_BIT = 2;
    localparam int unsigned CTL_RECORD_BIT = 3;
    localparam int unsigned EXC_EXCESS_BIT = 0;
    localparam int unsigned EXC_SUMMARY_BIT = 1;
    localparam int unsigned CND_SUMMARY_BIT = 0;
    localparam int unsigned CND_EQUAL_BIT = 1;
    localparam int unsigned CND_GREATER_BIT = 2;
    localparam int unsigned CND_LESS_BIT = 3;

    // ****************************************
    // arithmetic constants
    // ****************************************
    localparam logic [31:0] SAT_MAX = 32'h7fffffff;
    localparam logic [31:0] SAT_MIN = 32'h80000000;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [31:0] RST_WORD = 32'h00000000;
    localparam logic [2:0] RST_MODE = 3'h0;
    localparam logic [3:0] RST_COND = 4'h0;
    localparam logic [7:0] RST_ADDR = 8'h00;
    localparam logic [3:0] RST_STRB = 4'h0;

    // variant bits held in the control register
    typedef struct packed {
        logic record;
        logic ovf_enable;
        logic saturate;
    } nml_mode_s;

    typedef struct packed {
        logic [31:0] first_source_register;
        logic [31:0] second_source_register;
        logic [31:0] dest;
        nml_mode_s mode;
        logic arith_excess_flag;
        logic summary_flag;
        logic [3:0] first_condition_field;
    } nml_regs_s;

    typedef struct packed {
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        nml_regs_s regs;
    } nml_state_s;

endpackage : nml_pkg

// ### nml_core.sv
// signed low-halfword product subtracted from an accumulator word
// purely combinational; the caller registers the result
`timescale 1ns/1ns
module nml_core (
    input wire logic [31:0] first_source_register,
    input wire logic [31:0] second_source_register,
    input wire logic [31:0] acc,
    input wire logic saturate,
    output logic [31:0] result,
    output logic excess
);

    logic signed [31:0] product;
    logic signed [32:0] diff;

    always_comb begin
        product = $signed(first_source_register[15:0]) * $signed(second_source_register[15:0]); // RULE_01 RULE_02
        diff = $signed({acc[31], acc}) - $signed({product[31], product}); // RULE_02
        excess = diff[32] ^ diff[31]; // RULE_09
        if (saturate && excess) begin
            result = diff[32] ? nml_pkg::SAT_MIN : nml_pkg::SAT_MAX; // RULE_04
        end else begin
            result = diff[31:0]; // RULE_03
        end
    end

endmodule : nml_core

// ### nml_unit_assertions.sv
// handshake checker for the register bus of the unit
// assumes it is bound into nml_unit and sees only its ports
`timescale 1ns/1ns
module nml_unit_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ****************************************
    // channel handshakes
    // ****************************************
    a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid)
        else $error("response pending after reset");
    a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h05
        |=> s_axi_rresp == nml_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_err: cover property (s_axi_rvalid && s_axi_rresp == nml_pkg::RESP_SLVERR);
endmodule : nml_unit_checker
bind nml_unit nml_unit_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ### nml_axi_host.sv
// register bus master standing for the processor side of the unit
// assumes one clock; waits for each answer until the bench's own watchdog ends the run
`timescale 1ns/1ns
module nml_axi_host (
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // ****************************************
    // bus cycles
    // ****************************************
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    end

    // byte strobes of the next write; the bench narrows them for merge cases
    logic [3:0] wr_strb = 4'hf;

    // handshakes are judged at the falling edge, where nothing changes
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit ha;
        bit hw;
        bit hb = 1'b0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, wr_strb};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!hb) begin
            @(negedge aclk);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            hb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ha) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
            if (hw) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
        end
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ha;
        bit hv = 1'b0;
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        while (!hv) begin
            @(negedge aclk);
            ha = s_axi_arvalid && s_axi_arready;
            hv = s_axi_rvalid;
            {d, r} = {s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
            if (ha) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
        end
        s_axi_rready <= 1'b0;
    endtask : rd
endmodule : nml_axi_host

// ### nml_unit_tb.sv
// self-checking bench of the negative low-halfword multiply-accumulate unit
// assumes nml_axi_host as bus master and the bound checker
`timescale 1ns/1ns
module nml_unit_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot = 3'h0;
    logic [2:0] s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata, s_axi_rdata, a, b, d, v;
    logic [3:0] s_axi_wstrb, co, ec;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, xo, eo;
    logic [32:0] x;
    int n_fail = 0;
    int check_count = 0;

    always #5 aclk = ~aclk;

    nml_unit dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    nml_axi_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    // ****************************************
    // expectations and reporting
    // ****************************************
    // returns {excess, written word}
    function automatic logic [32:0] nml_expect(input logic [31:0] a, b, d, input logic s);
        logic signed [31:0] p;
        logic [32:0] df;
        p = $signed(a[15:0]) * $signed(b[15:0]);
        df = {d[31], d} - {p[31], p};
        if (s && (df[32] ^ df[31])) return {1'b1, df[32] ? 32'h80000000 : 32'h7fffffff};
        return {df[32] ^ df[31], df[31:0]};
    endfunction : nml_expect

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", n, e, g);
            n_fail++;
        end
    endtask : chk

    task automatic complete_run();
        if (n_fail == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run

    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        complete_run();
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        void'($urandom(7288));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            host.rd(8'(i * 4), v, r);
            chk("reset value", 32'h0, v);
        end
        host.wr(8'h20, 32'h5, r);
        chk("unmapped write resp", 32'(nml_pkg::RESP_SLVERR), 32'(r));
        host.rd(8'h3c, v, r);
        chk("unmapped read resp", 32'(nml_pkg::RESP_SLVERR), 32'(r));
        chk("unmapped read data", 32'h0, v);
        for (int m = 0; m < 8; m++) begin
            for (int k = 0; k < 12; k++) begin
                {a, b, d} = {$urandom, $urandom, $urandom};
                {xo, co} = 6'($urandom);
                if (k == 0) {a, b, d} = {32'hffff8000, 32'h12348000, 32'h80000000};
                if (k == 1) {a, b, d} = {32'h00008000, 32'h00007fff, 32'h7fffffff};
                if (k == 2) {a, b, d} = {32'h55550003, 32'habcdfffe, 32'hfffffffa};
                host.wr(nml_pkg::OFS_FIRST_SRC, a, r);
                host.wr(nml_pkg::OFS_SECOND_SRC, b, r);
                host.wr(nml_pkg::OFS_DEST, d, r);
                host.wr(nml_pkg::OFS_EXCEPTION, {30'h0, xo}, r);
                host.wr(nml_pkg::OFS_CONDITION, {28'h0, co}, r);
                host.wr(nml_pkg::OFS_CONTROL, {28'h0, 3'(m), 1'b1}, r);
                chk("execute resp", 32'(nml_pkg::RESP_OKAY), 32'(r));
                x = nml_expect(a, b, d, m[0]);
                eo = m[1] ? {xo[1] | x[32], x[32]} : xo;
                ec = m[2] ? {x[31], ~x[31] & (|x[31:0]), ~|x[31:0], eo[1]} : co;
                host.rd(nml_pkg::OFS_DEST, v, r);
                chk("dest", x[31:0], v);
                chk("read resp", 32'(nml_pkg::RESP_OKAY), 32'(r));
                host.rd(nml_pkg::OFS_EXCEPTION, v, r);
                chk("exception", {30'h0, eo}, v);
                host.rd(nml_pkg::OFS_CONDITION, v, r);
                chk("condition", {28'h0, ec}, v);
                host.rd(nml_pkg::OFS_CONTROL, v, r);
                chk("control", {28'h0, 3'(m), 1'b0}, v);
            end
        end
        // partial strobes merge bytes; a control write without byte 0 does not execute
        host.wr(nml_pkg::OFS_DEST, 32'h11223344, r);
        host.wr_strb = 4'h2;
        host.wr(nml_pkg::OFS_DEST, 32'haabbccdd, r);
        host.wr(nml_pkg::OFS_CONTROL, 32'h0000000f, r);
        host.wr_strb = 4'hf;
        host.rd(nml_pkg::OFS_DEST, v, r);
        chk("byte merge", 32'h1122cc44, v);
        host.rd(nml_pkg::OFS_CONTROL, v, r);
        chk("control no strobe", 32'he, v);
        // second reset in mid-run clears the registers again
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        host.rd(nml_pkg::OFS_DEST, v, r);
        chk("dest after reset", 32'h0, v);
        complete_run();
    end
endmodule : nml_unit_tb
